// *** verilog/hbp_pkg.sv ***
package hbp_pkg;

    localparam int CLK_PERIOD_NS = 10;

    localparam int ADDR_W = 7;
    localparam int DATA_W = 16;
    localparam int WSEL_W = 2;
    localparam int CNT_W  = 8;

    localparam logic [CNT_W-1:0] CNT_MAX  = 8'hFF;
    localparam logic [CNT_W-1:0] CNT_ONE  = 8'h01;
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;

    // Host timing figures
    localparam int T_CYCLE_NS = 165;
    localparam int T_CSL_NS   = 32;
    localparam int T_CSH_NS   = 13;
    localparam int T_CSDV_NS  = 30;
    localparam int T_ADV_NS   = 40;
    localparam int T_ACYC_NS  = 165;
    localparam int T_DOFF_NS  = 7;

    // Least times round up, longest round down, never under one cycle
    localparam int CYCLE_CYC = (T_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CSL_CYC   = (T_CSL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CSH_CYC   = (T_CSH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACYC_CYC  = (T_ACYC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CSDV_CYC  = (T_CSDV_NS / CLK_PERIOD_NS < 1) ? 1 :
                               T_CSDV_NS / CLK_PERIOD_NS;
    localparam int ADV_CYC   = (T_ADV_NS / CLK_PERIOD_NS < 1) ? 1 :
                               T_ADV_NS / CLK_PERIOD_NS;
    localparam int DOFF_CYC  = (T_DOFF_NS / CLK_PERIOD_NS < 1) ? 1 :
                               T_DOFF_NS / CLK_PERIOD_NS;

    // Sampling is one cycle coarse, so a check allows one sample of slack
    localparam logic [CNT_W-1:0] CYCLE_LIM = CNT_W'(CYCLE_CYC - 1);
    localparam logic [CNT_W-1:0] CSL_LIM   = CNT_W'(CSL_CYC - 1);
    localparam logic [CNT_W-1:0] CSH_LIM   = CNT_W'(CSH_CYC - 1);
    localparam logic [CNT_W-1:0] ACYC_LIM  = CNT_W'(ACYC_CYC - 1);

    localparam logic [CNT_W-1:0] BURST_MAX = 8'h10;

    // Synchroniser bundle layout
    localparam int SY_CS   = 0;
    localparam int SY_RD   = 1;
    localparam int SY_WR   = 2;
    localparam int SY_FSEL = 3;
    localparam int SY_ADDR = 4;
    localparam int SY_DATA = SY_ADDR + ADDR_W;
    localparam int SY_W    = SY_DATA + DATA_W;

    localparam logic [SY_W-1:0] SY_RST = {{(SY_W-3){1'b0}}, 3'h7};

endpackage

// *** verilog/hbp_sync.sv ***
`timescale 1ns/1ns
module hbp_sync #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst_b,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meta_ff <= RST_VAL;
            sync_ff <= RST_VAL;
        end else begin
            meta_ff <= i_async;
            sync_ff <= meta_ff;
        end
    end

    assign o_sync = sync_ff;

endmodule

// *** verilog/hbp_acc_track.sv ***
`timescale 1ns/1ns
module hbp_acc_track (
    input  wire logic                      i_clk,
    input  wire logic                      i_rst_b,
    input  wire logic                      i_act,
    input  wire logic [hbp_pkg::ADDR_W-1:0] i_addr,
    output logic                           o_start,
    output logic                           o_end,
    output logic                           o_addr_chg
);

    logic                       act_ff;
    logic [hbp_pkg::ADDR_W-1:0] addr_ff;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            act_ff  <= 1'b0;
            addr_ff <= '0;
        end else begin
            act_ff  <= i_act;
            addr_ff <= i_addr;
        end
    end

    // both low starts, either high ends
    assign o_start    = i_act & ~act_ff;
    assign o_end      = ~i_act & act_ff;
    // new address inside one strobe is a new access
    assign o_addr_chg = i_act & act_ff & (i_addr != addr_ff);

endmodule

// *** verilog/hbp_host_port.sv ***
`timescale 1ns/1ns
module hbp_host_port (
    input  wire logic                       i_core_clk,
    input  wire logic                       i_rst_b,
    input  wire logic                       i_host_select_n,
    input  wire logic                       i_host_read_strobe_n,
    input  wire logic                       i_host_write_strobe_n,
    input  wire logic                       i_fifo_sel,
    input  wire logic [hbp_pkg::ADDR_W-1:0] i_addr,
    input  wire logic [hbp_pkg::DATA_W-1:0] i_data,
    output logic      [hbp_pkg::DATA_W-1:0] o_data,
    output logic                            o_data_oe,
    output logic      [hbp_pkg::ADDR_W-1:0] o_reg_addr,
    output logic                            o_reg_rd,
    output logic                            o_cnt_latch,
    input  wire logic [hbp_pkg::DATA_W-1:0] i_reg_rdata,
    output logic      [hbp_pkg::WSEL_W-1:0] o_rxf_word_sel,
    output logic                            o_rxf_pop,
    input  wire logic [hbp_pkg::DATA_W-1:0] i_rxf_rdata,
    output logic                            o_reg_wr,
    output logic      [hbp_pkg::ADDR_W-1:0] o_reg_wr_addr,
    output logic      [hbp_pkg::DATA_W-1:0] o_reg_wdata,
    output logic                            o_wr_fifo_sel,
    output logic                            o_burst_over,
    output logic                            o_timing_err
);

    logic                       rst_meta_ff;
    logic                       rst_sync_ff;
    wire                        rst_b;

    logic [hbp_pkg::SY_W-1:0]   pins_s;
    wire                        cs_s;
    wire                        rd_s;
    wire                        wr_s;
    wire                        fsel_s;
    wire  [hbp_pkg::ADDR_W-1:0] addr_s;
    wire  [hbp_pkg::DATA_W-1:0] data_s;

    wire                        act_r;
    wire                        act_w;
    wire                        act_any;
    logic                       rd_start;
    logic                       rd_end;
    logic                       rd_chg;
    logic                       wr_start;
    logic                       wr_end;
    wire                        any_start;
    wire                        any_end;
    wire                        acc_done;
    wire                        load_now;
    wire                        load_fsel;

    logic [hbp_pkg::DATA_W-1:0] data_ff;
    logic                       oe_ff;
    logic                       cur_fsel_ff;
    logic                       reload_ff;
    logic [hbp_pkg::CNT_W-1:0]  bcnt_ff;
    logic                       over_ff;

    logic [hbp_pkg::CNT_W-1:0]  low_cnt_ff;
    logic [hbp_pkg::CNT_W-1:0]  high_cnt_ff;
    logic [hbp_pkg::CNT_W-1:0]  since_ff;
    logic [hbp_pkg::CNT_W-1:0]  acyc_ff;
    logic                       seen_ff;
    logic                       err_ff;
    wire                        err_low;
    wire                        err_gap;
    wire                        err_acyc;

    logic [hbp_pkg::DATA_W-1:0] wdata_ff;
    logic [hbp_pkg::ADDR_W-1:0] waddr_ff;
    logic                       wfsel_ff;

    function automatic logic [hbp_pkg::DATA_W-1:0] pick_data(
        input logic                       fsel,
        input logic [hbp_pkg::DATA_W-1:0] rx,
        input logic [hbp_pkg::DATA_W-1:0] rg
    );
        pick_data = fsel ? rx : rg;
    endfunction

    function automatic logic [hbp_pkg::CNT_W-1:0] sat_inc(
        input logic [hbp_pkg::CNT_W-1:0] c
    );
        sat_inc = (c == hbp_pkg::CNT_MAX) ? c : c + hbp_pkg::CNT_ONE;
    endfunction

    // Reset release through two flops
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    assign rst_b = rst_sync_ff;

    // Strobes, address and data share one synchroniser so they stay aligned
    hbp_sync #(
        .W       (hbp_pkg::SY_W),
        .RST_VAL (hbp_pkg::SY_RST)
    ) u_sync (
        .i_clk   (i_core_clk),
        .i_rst_b (rst_b),
        .i_async ({i_data, i_addr, i_fifo_sel, i_host_write_strobe_n,
                   i_host_read_strobe_n, i_host_select_n}),
        .o_sync  (pins_s)
    );

    assign cs_s   = pins_s[hbp_pkg::SY_CS];
    assign rd_s   = pins_s[hbp_pkg::SY_RD];
    assign wr_s   = pins_s[hbp_pkg::SY_WR];
    assign fsel_s = pins_s[hbp_pkg::SY_FSEL];
    assign addr_s = pins_s[hbp_pkg::SY_DATA-1:hbp_pkg::SY_ADDR];
    assign data_s = pins_s[hbp_pkg::SY_W-1:hbp_pkg::SY_DATA];

    // read is select and read strobe low
    assign act_r   = ~cs_s & ~rd_s;
    // write is select and write strobe low; a read wins an overlap
    assign act_w   = ~cs_s & ~wr_s & ~act_r;
    assign act_any = act_r | act_w;

    hbp_acc_track u_rd_track (
        .i_clk      (i_core_clk),
        .i_rst_b    (rst_b),
        .i_act      (act_r),
        .i_addr     (addr_s),
        .o_start    (rd_start),
        .o_end      (rd_end),
        .o_addr_chg (rd_chg)
    );

    hbp_acc_track u_wr_track (
        .i_clk      (i_core_clk),
        .i_rst_b    (rst_b),
        .i_act      (act_w),
        .i_addr     (addr_s),
        .o_start    (wr_start),
        .o_end      (wr_end),
        .o_addr_chg ()
    );

    assign any_start = rd_start | wr_start;
    assign any_end   = rd_end | wr_end;

    // each address step inside a burst closes one access
    assign acc_done  = rd_end | rd_chg;
    // Loads on read start, or one cycle after a step so a pop settles first
    assign load_now  = rd_start | reload_ff;
    assign load_fsel = rd_start ? fsel_s : cur_fsel_ff;

    // full address still drives the core, the two low address bits pick one of four FIFO words
    assign o_reg_addr     = addr_s;
    assign o_rxf_word_sel = addr_s[hbp_pkg::WSEL_W-1:0];
    assign o_reg_rd       = load_now & ~load_fsel;
    assign o_cnt_latch    = rd_start & ~fsel_s;
    // one pop per finished FIFO access
    assign o_rxf_pop      = acc_done & cur_fsel_ff;

    // data captured from the start edge, bus driven while the read lasts
    always_ff @(posedge i_core_clk or negedge rst_b) begin
        if (!rst_b) begin
            data_ff <= 16'h0000;
            oe_ff   <= 1'b0;
        end else begin
            if (load_now) begin
                data_ff <= pick_data(load_fsel, i_rxf_rdata, i_reg_rdata);
            end
            if (rd_start) begin
                oe_ff <= 1'b1;
            end else if (rd_end) begin
                oe_ff <= 1'b0;
            end
        end
    end

    assign o_data    = data_ff;
    assign o_data_oe = oe_ff;

    // FIFO select of each access kept until that access closes
    always_ff @(posedge i_core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cur_fsel_ff <= 1'b0;
            reload_ff   <= 1'b0;
        end else begin
            if (rd_start | rd_chg) begin
                cur_fsel_ff <= fsel_s;
            end
            // new burst address answered within the address window
            reload_ff <= rd_chg;
        end
    end

    // burst length watched; FIFO bursts never counted against it
    always_ff @(posedge i_core_clk or negedge rst_b) begin
        if (!rst_b) begin
            bcnt_ff <= hbp_pkg::CNT_ZERO;
            over_ff <= 1'b0;
        end else if (rd_start) begin
            bcnt_ff <= hbp_pkg::CNT_ONE;
            over_ff <= 1'b0;
        end else if (rd_chg) begin
            bcnt_ff <= sat_inc(bcnt_ff);
            if (~fsel_s && bcnt_ff >= hbp_pkg::BURST_MAX) begin
                over_ff <= 1'b1;
            end
        end
    end

    assign o_burst_over = over_ff;

    // Host timing watch, only a diagnostic: accesses are served regardless
    always_ff @(posedge i_core_clk or negedge rst_b) begin
        if (!rst_b) begin
            low_cnt_ff  <= hbp_pkg::CNT_ZERO;
            high_cnt_ff <= hbp_pkg::CNT_ZERO;
            since_ff    <= hbp_pkg::CNT_ZERO;
            acyc_ff     <= hbp_pkg::CNT_ZERO;
            seen_ff     <= 1'b0;
        end else begin
            if (any_start) begin
                low_cnt_ff <= hbp_pkg::CNT_ONE;
                since_ff   <= hbp_pkg::CNT_ONE;
                seen_ff    <= 1'b1;
            end else begin
                since_ff <= sat_inc(since_ff);
                if (act_any) begin
                    low_cnt_ff <= sat_inc(low_cnt_ff);
                end
            end
            if (act_any) begin
                high_cnt_ff <= hbp_pkg::CNT_ZERO;
            end else begin
                high_cnt_ff <= sat_inc(high_cnt_ff);
            end
            if (rd_start | rd_chg) begin
                acyc_ff <= hbp_pkg::CNT_ONE;
            end else begin
                acyc_ff <= sat_inc(acyc_ff);
            end
        end
    end

    // short joint assertion; same for writes
    assign err_low  = any_end & (low_cnt_ff < hbp_pkg::CSL_LIM);
    // short idle or short cycle; likewise between bursts
    assign err_gap  = any_start & seen_ff &
                      ((high_cnt_ff < hbp_pkg::CSH_LIM) |
                       (since_ff < hbp_pkg::CYCLE_LIM));
    assign err_acyc = rd_chg & (acyc_ff < hbp_pkg::ACYC_LIM);

    always_ff @(posedge i_core_clk or negedge rst_b) begin
        if (!rst_b) begin
            err_ff <= 1'b0;
        end else begin
            err_ff <= err_low | err_gap | err_acyc;
        end
    end

    assign o_timing_err = err_ff;

    // write data sampled while strobes low, committed when released
    always_ff @(posedge i_core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wdata_ff <= 16'h0000;
            waddr_ff <= '0;
            wfsel_ff <= 1'b0;
        end else if (act_w) begin
            wdata_ff <= data_s;
            waddr_ff <= addr_s;
            wfsel_ff <= fsel_s;
        end
    end

    // Last sample before release is used, since data hold may be zero
    assign o_reg_wr      = wr_end;
    assign o_reg_wr_addr = waddr_ff;
    assign o_reg_wdata   = wdata_ff;
    assign o_wr_fifo_sel = wfsel_ff;

endmodule

// *** verif/hbp_host_port_assertions.sv ***
`timescale 1ns/1ns
module hbp_host_port_chk (
    input wire logic                       i_core_clk,
    input wire logic                       i_rst_b,
    input wire logic                       i_host_select_n,
    input wire logic                       i_host_read_strobe_n,
    input wire logic                       i_host_write_strobe_n,
    input wire logic                       i_fifo_sel,
    input wire logic [hbp_pkg::ADDR_W-1:0] i_addr,
    input wire logic [hbp_pkg::DATA_W-1:0] i_reg_rdata,
    input wire logic [hbp_pkg::DATA_W-1:0] o_data,
    input wire logic                       o_data_oe,
    input wire logic                       o_reg_rd,
    input wire logic                       o_cnt_latch,
    input wire logic [hbp_pkg::WSEL_W-1:0] o_rxf_word_sel,
    input wire logic                       o_rxf_pop,
    input wire logic                       o_reg_wr,
    input wire logic                       o_burst_over,
    input wire logic                       o_timing_err
);
    wire rd_act = !i_host_select_n && !i_host_read_strobe_n;
    wire wr_act = !i_host_select_n && !i_host_write_strobe_n;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);
    // Windows allow for the two synchroniser stages
    property p_cnt_latch; $rose(rd_act) && !i_fifo_sel |-> ##[1:4] o_cnt_latch; endproperty
    a_cnt_latch: assert property (p_cnt_latch) else $error("no counter snapshot");
    property p_reg_load; o_reg_rd |=> o_data == $past(i_reg_rdata); endproperty
    a_reg_load: assert property (p_reg_load) else $error("read data not loaded");
    property p_oe_on; $rose(rd_act) |-> ##[1:4] o_data_oe; endproperty
    a_oe_on: assert property (p_oe_on) else $error("data bus not driven");
    property p_oe_off; $fell(rd_act) |-> ##[1:4] !o_data_oe; endproperty
    a_oe_off: assert property (p_oe_off) else $error("data bus not released");
    property p_fifo_no_reg; (rd_act && i_fifo_sel)[*4] |-> !o_reg_rd && !o_cnt_latch; endproperty
    a_fifo_no_reg: assert property (p_fifo_no_reg) else $error("register read in fifo mode");
    property p_word_sel; $stable(i_addr)[*6] |-> o_rxf_word_sel == i_addr[1:0]; endproperty
    a_word_sel: assert property (p_word_sel) else $error("word select wrong");
    property p_pop_end;
        (rd_act && i_fifo_sel)[*4] ##1 (!rd_act && i_fifo_sel) |-> ##[1:4] o_rxf_pop;
    endproperty
    a_pop_end: assert property (p_pop_end) else $error("no pop at fifo read end");
    property p_wr_commit;
        (wr_act && i_host_read_strobe_n)[*4] ##1 !wr_act |-> ##[1:4] o_reg_wr;
    endproperty
    a_wr_commit: assert property (p_wr_commit) else $error("write not committed");
    // New address answered exactly four samples later
    property p_addr_data;
        rd_act && !i_fifo_sel && $changed(i_addr) |-> ##4 o_data == $past(i_reg_rdata);
    endproperty
    a_addr_data: assert property (p_addr_data) else $error("burst data late");
    c_reg_wr: cover property (o_reg_wr);
    c_burst_over: cover property (o_burst_over);
    c_timing_err: cover property (o_timing_err);
    c_pop: cover property (o_rxf_pop);
endmodule
bind hbp_host_port hbp_host_port_chk hbp_host_port_chk_inst (.i_core_clk, .i_rst_b,
    .i_host_select_n, .i_host_read_strobe_n, .i_host_write_strobe_n, .i_fifo_sel, .i_addr,
    .i_reg_rdata, .o_data, .o_data_oe, .o_reg_rd, .o_cnt_latch, .o_rxf_word_sel, .o_rxf_pop,
    .o_reg_wr, .o_burst_over, .o_timing_err);

// *** verif/hbp_host_model.sv ***
`timescale 1ns/1ns
module hbp_host_model (
    input  wire logic        i_clk,
    input  wire logic [15:0] i_bus,
    output logic             o_cs_n,
    output logic             o_rd_n,
    output logic             o_wr_n,
    output logic             o_fsel,
    output logic [6:0]       o_addr,
    output logic [15:0]      o_hdata
);
    logic [15:0] got[$];
    initial begin
        o_cs_n = 1'b1;
        o_rd_n = 1'b1;
        o_wr_n = 1'b1;
        o_fsel = 1'b0;
        o_addr = 7'h00;
        o_hdata = 16'h0000;
    end
    // each 16-bit access held h cycles
    task automatic run(input logic w, input logic f, input logic [6:0] a0, input int n,
                       input int h, input logic [15:0] d);
        @(posedge i_clk);
        o_cs_n <= 1'b0;
        o_rd_n <= w;
        o_wr_n <= !w;
        o_fsel <= f;
        for (int i = 0; i < n; i++) begin
            o_addr <= a0 + 7'(i);
            o_hdata <= d + 16'(i);
            repeat (h) @(posedge i_clk);
            if (!w) got.push_back(i_bus);
        end
        // strobes high 30 ns after a read and 360 ns after a write, released bus shows no stale data
        o_cs_n <= 1'b1;
        o_rd_n <= 1'b1;
        o_wr_n <= 1'b1;
        o_hdata <= ~o_hdata;
        repeat (3) @(posedge i_clk);
        if (w) repeat (33) @(posedge i_clk);
    endtask
endmodule

// *** verif/testbench.sv ***
`timescale 1ns/1ns
module testbench;
    logic        i_core_clk = 1'b0;
    logic        i_rst_b = 1'b0;
    logic        cs_n, rd_n, wr_n, fsel, o_data_oe, o_reg_rd, o_rxf_pop, o_reg_wr;
    logic        o_burst_over, o_timing_err, wf;
    logic [6:0]  addr, o_reg_addr, wa;
    logic [15:0] hdata, bus, o_data, o_reg_wdata, wd;
    logic [1:0]  o_rxf_word_sel;
    logic [13:0] pops, p0;
    int          n_errors = 0, n_checks = 0, n_wr = 0, n_terr = 0;
    always #5 i_core_clk = ~i_core_clk;
    assign bus = o_data_oe ? o_data : hdata;
    hbp_host_model hbp_host_model_inst (.i_clk(i_core_clk), .i_bus(bus), .o_cs_n(cs_n),
        .o_rd_n(rd_n), .o_wr_n(wr_n), .o_fsel(fsel), .o_addr(addr), .o_hdata(hdata));
    hbp_host_port hbp_host_port_inst (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
        .i_host_select_n(cs_n), .i_host_read_strobe_n(rd_n), .i_host_write_strobe_n(wr_n),
        .i_fifo_sel(fsel), .i_addr(addr), .i_data(bus), .o_data(o_data),
        .o_data_oe(o_data_oe), .o_reg_addr(o_reg_addr), .o_reg_rd(o_reg_rd),
        .o_cnt_latch(), .i_reg_rdata({8'hA5, 1'b0, o_reg_addr}),
        .o_rxf_word_sel(o_rxf_word_sel), .o_rxf_pop(o_rxf_pop),
        .i_rxf_rdata({pops, o_rxf_word_sel}), .o_reg_wr(o_reg_wr), .o_reg_wr_addr(wa),
        .o_reg_wdata(wd), .o_wr_fifo_sel(wf), .o_burst_over(o_burst_over),
        .o_timing_err(o_timing_err));
    always @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pops <= 14'h0000;
        end else begin
            pops <= pops + 14'(o_rxf_pop);
            n_wr <= n_wr + int'(o_reg_wr);
            n_terr <= n_terr + int'(o_timing_err);
        end
    end
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task settle;
        repeat (2) @(posedge i_core_clk);
        #1;
    endtask
    task reg_read;
        hbp_host_model_inst.got.delete();
        hbp_host_model_inst.run(1'b0, 1'b0, 7'h55, 1, 17, 16'h0000);
        chk("reg data", 16'hA555, hbp_host_model_inst.got[0]);
    endtask
    task reg_burst(input int n, input logic ov);
        hbp_host_model_inst.got.delete();
        hbp_host_model_inst.run(1'b0, 1'b0, 7'h10, n, 17, 16'h0000);
        for (int i = 0; i < n; i++)
            chk("burst data", {8'hA5, 1'b0, 7'h10 + 7'(i)}, hbp_host_model_inst.got[i]);
        chk("burst over", 16'(ov), 16'(o_burst_over));
    endtask
    task fifo_burst(input logic [6:0] a0, input int n);
        hbp_host_model_inst.got.delete();
        p0 = pops;
        hbp_host_model_inst.run(1'b0, 1'b1, a0, n, 17, 16'h0000);
        settle();
        for (int i = 0; i < n; i++)
            chk("fifo data", {p0 + 14'(i), a0[1:0] + 2'(i)}, hbp_host_model_inst.got[i]);
        chk("pop count", 16'(p0) + 16'(n), 16'(pops));
        chk("fifo burst over", 16'h0000, 16'(o_burst_over));
    endtask
    task wr_cycle;
        hbp_host_model_inst.run(1'b1, 1'b0, 7'h33, 1, 17, 16'hBEEF);
        settle();
        chk("write count", 16'h0001, 16'(n_wr));
        chk("write addr", 16'h0033, 16'(wa));
        chk("write data", 16'hBEEF, wd);
        chk("write fifo sel", 16'h0000, 16'(wf));
        hbp_host_model_inst.run(1'b1, 1'b1, 7'h12, 1, 17, 16'h1234);
        settle();
        chk("write count", 16'h0002, 16'(n_wr));
        chk("write addr", 16'h0012, 16'(wa));
        chk("write data", 16'h1234, wd);
        chk("write fifo sel", 16'h0001, 16'(wf));
    endtask
    task short_read;
        chk("timing errors", 16'h0000, 16'(n_terr));
        hbp_host_model_inst.run(1'b0, 1'b0, 7'h01, 1, 2, 16'h0000);
        settle();
        chk("short read flag", 16'h0001, 16'(n_terr));
    endtask
    task end_of_test;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge i_core_clk);
        i_rst_b <= 1'b1;
        repeat (5) @(posedge i_core_clk);
        reg_read();
        reg_burst(17, 1'b1);
        reg_burst(16, 1'b0);
        fifo_burst(7'h7E, 1);
        fifo_burst(7'h00, 20);
        wr_cycle();
        short_read();
        end_of_test();
    end
    // Whole run needs under 1500 cycles
    initial begin
        repeat (5000) @(posedge i_core_clk);
        n_errors++;
        end_of_test();
    end
endmodule
